//--- design/sps_host.sv
// Purpose: System logic that steps, presets, tests and programs the sequencer.
// Assumes: User commands are synchronous single-cycle pulses or levels.
// Notes: Steps come from a divider, never faster than the rated maximum.
`timescale 1ns/100ps
`default_nettype none
module sps_host
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    sps_link_if.host link,
    input wire logic run_en,
    input wire logic test_mode,
    input wire logic preset_req,
    input wire logic pin_idle,
    input wire logic [SPS_IN_W-1:0] user_inputs,
    input wire logic prog_we,
    input wire logic [5:0] prog_line,
    input wire logic [SPS_AND_W-1:0] prog_and,
    input wire logic [SPS_OR_W-1:0] prog_or,
    input wire logic prog_delete_test,
    input wire logic prog_mode_we,
    input wire logic prog_mode_oe,
    output logic [SPS_OUT_W-1:0] outputs_seen,
    output logic outputs_seen_oe,
    output logic busy
);

    sps_host_t q;
    sps_host_t d;

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    always_comb begin
        d = q;
        d.step = 1'b0;
        d.seen = link.registered_outputs;
        d.seen_oe = link.outputs_oe;

        // Test run: outputs loop back, pin held low.
        if (test_mode) begin
            d.upper = link.registered_outputs;
        end else begin
            d.upper = user_inputs[15:8];
        end
        d.lower = user_inputs[7:0];

        unique case (q.hs)
            SPS_H_BOOT: begin
                // No step until the power-up setup has passed.
                d.pin = 1'b0;
                d.cnt = q.cnt + 4'h1;
                if (q.cnt >= 4'(SPS_PUP_SETUP_CYC - 1)) begin
                    d.hs = SPS_H_RUN;
                    d.cnt = 4'h0;
                end
            end
            SPS_H_RUN: begin
                d.pin = test_mode ? 1'b0 : pin_idle;
                if (preset_req && !test_mode) begin
                    d.pin = 1'b1;
                    d.cnt = 4'h0;
                    d.hs = SPS_H_PRESET;
                end else if (run_en) begin
                    // Divider keeps the rate at or below the rated maximum.
                    if (q.cnt >= 4'(SPS_STEP_DIV - 1)) begin
                        d.cnt = 4'h0;
                        d.step = 1'b1;
                    end else begin
                        d.cnt = q.cnt + 4'h1;
                    end
                end
            end
            SPS_H_PRESET: begin
                d.pin = 1'b1;
                d.cnt = q.cnt + 4'h1;
                if (q.cnt >= 4'(SPS_PRE_WIDTH_CYC - 1)) begin
                    d.pin = 1'b0;
                    d.cnt = 4'h0;
                    d.hs = SPS_H_RECOV;
                end
            end
            SPS_H_RECOV: begin
                // Pin stays low for the setup time before any step.
                d.pin = 1'b0;
                d.cnt = q.cnt + 4'h1;
                if (q.cnt >= 4'(SPS_PRE_SETUP_CYC - 1)) begin
                    d.cnt = 4'h0;
                    d.hs = SPS_H_RUN;
                end
            end
        endcase

        // ************************************************************
        // Programming
        // ************************************************************
        d.fwe = prog_we;
        d.fline = prog_line;
        d.fand = prog_and;
        d.f_or = prog_or;
        d.fdel = prog_delete_test;
        d.fmwe = prog_mode_we;
        d.fmoe = prog_mode_oe;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.upper_inputs = q.upper;
    assign link.lower_inputs = q.lower;
    assign link.seq_step = q.step;
    assign link.preset_or_output_enable = q.pin;
    assign link.fuse_we = q.fwe;
    assign link.fuse_line = q.fline;
    assign link.fuse_and = q.fand;
    assign link.fuse_or = q.f_or;
    assign link.fuse_delete_test = q.fdel;
    assign link.fuse_mode_we = q.fmwe;
    assign link.fuse_mode_oe = q.fmoe;
    assign outputs_seen = q.seen;
    assign outputs_seen_oe = q.seen_oe;
    assign busy = (q.hs != SPS_H_RUN);

endmodule // sps_host
`default_nettype wire

//--- design/sps_pkg.sv
// Purpose: Shared constants and types for the preset/test-array sequencer.
// Assumes: One 20 MHz clock; sequencer advances on a one-cycle step pulse.
// Notes: Each rule below is tagged at the logic that keeps it.
// Behaviour
// - Test product lines 48, 49 factory programmed.
// - Test run loops outputs to upper inputs.
// - Programmer deletes test lines 48 and 49.
// - Step rate independent of programmed terms.
// - Power-up presets all register bits high.
// - Preset pin forces high, ignores steps.
// - Wait setup time after power-up before stepping.
// - Preset low 8 ns before step; no fall.
// - First step after release updates registers.
// - Mode fuse: preset or active-low enable.
// - Six state bits fed back, eight outputs.
package sps_pkg;

    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam int SPS_IN_W = 16;
    localparam int SPS_ST_W = 6;
    localparam int SPS_OUT_W = 8;
    localparam int SPS_REG_W = SPS_ST_W + SPS_OUT_W;
    localparam int SPS_LIT_W = SPS_IN_W + SPS_ST_W;
    localparam int SPS_AND_W = 2 * SPS_LIT_W;
    localparam int SPS_OR_W = 2 * SPS_REG_W;
    localparam int SPS_USER_LINES = 48;
    localparam int SPS_LINES = 50;
    localparam int SPS_TEST_LINE_A = 48;
    localparam int SPS_TEST_LINE_B = 49;

    // ****************************************************************
    // Factory test pattern and reset values
    // ****************************************************************
    localparam logic [43:0] SPS_T48_AND = 44'h000_0000_0001;
    localparam logic [27:0] SPS_T48_OR = 28'h555_5555;
    localparam logic [43:0] SPS_T49_AND = 44'h000_0000_0002;
    localparam logic [27:0] SPS_T49_OR = 28'haaa_aaaa;
    localparam logic [43:0] SPS_AND_RST = 44'hfff_ffff_ffff;
    localparam logic [27:0] SPS_OR_RST = 28'h000_0000;
    localparam logic [5:0] SPS_ST_RST = 6'h3f;
    localparam logic [7:0] SPS_OUT_RST = 8'hff;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SPS_CLK_MHZ = 20;
    localparam int SPS_CLK_NS = 50;
    localparam int SPS_FMAX_MHZ = 50;
    localparam int SPS_PRE_SETUP_NS = 8;
    localparam int SPS_PRE_WIDTH_NS = 15;
    localparam int SPS_PUP_SETUP_NS = 8;
    localparam int SPS_PRE_SETUP_CYC = (SPS_PRE_SETUP_NS + SPS_CLK_NS - 1) / SPS_CLK_NS;
    localparam int SPS_PRE_WIDTH_CYC = (SPS_PRE_WIDTH_NS + SPS_CLK_NS - 1) / SPS_CLK_NS;
    localparam int SPS_PUP_SETUP_CYC = (SPS_PUP_SETUP_NS + SPS_CLK_NS - 1) / SPS_CLK_NS;
    localparam int SPS_STEP_MIN_CYC = (SPS_CLK_MHZ + SPS_FMAX_MHZ - 1) / SPS_FMAX_MHZ;
    localparam int SPS_STEP_DIV = 4;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic [SPS_ST_W-1:0] st;
        logic [SPS_OUT_W-1:0] outr;
        logic oe;
        logic mode_oe;
        logic test_live;
        logic [SPS_LINES-1:0][SPS_AND_W-1:0] and_f;
        logic [SPS_LINES-1:0][SPS_OR_W-1:0] or_f;
    } sps_dev_t;

    localparam sps_dev_t SPS_DEV_RST = '{
        st: SPS_ST_RST,
        outr: SPS_OUT_RST,
        oe: 1'b1,
        mode_oe: 1'b0,
        test_live: 1'b1,
        and_f: {SPS_T49_AND, SPS_T48_AND, {SPS_USER_LINES{SPS_AND_RST}}},
        or_f: {SPS_T49_OR, SPS_T48_OR, {SPS_USER_LINES{SPS_OR_RST}}}
    };

    typedef enum logic [1:0] {
        SPS_H_BOOT = 2'b00,
        SPS_H_RUN = 2'b01,
        SPS_H_PRESET = 2'b10,
        SPS_H_RECOV = 2'b11
    } sps_hstate_t;

    typedef struct packed {
        sps_hstate_t hs;
        logic [3:0] cnt;
        logic step;
        logic pin;
        logic [7:0] upper;
        logic [7:0] lower;
        logic fwe;
        logic [5:0] fline;
        logic [SPS_AND_W-1:0] fand;
        logic [SPS_OR_W-1:0] f_or;
        logic fdel;
        logic fmwe;
        logic fmoe;
        logic [7:0] seen;
        logic seen_oe;
    } sps_host_t;

endpackage

//--- design/sps_link_if.sv
// Purpose: Pins and programming lines between sequencer and system logic.
// Assumes: All signals synchronous to the one system clock.
// Notes: Outputs carry an enable; the bench checks the enable and forms no 3-state level.
`timescale 1ns/100ps
`default_nettype none
interface sps_link_if;
    import sps_pkg::*;
    logic [7:0] upper_inputs;
    logic [7:0] lower_inputs;
    logic seq_step;
    logic preset_or_output_enable;
    logic [7:0] registered_outputs;
    logic outputs_oe;
    logic fuse_we;
    logic [5:0] fuse_line;
    logic [SPS_AND_W-1:0] fuse_and;
    logic [SPS_OR_W-1:0] fuse_or;
    logic fuse_delete_test;
    logic fuse_mode_we;
    logic fuse_mode_oe;

    modport dev (
        input upper_inputs, lower_inputs, seq_step, preset_or_output_enable,
        input fuse_we, fuse_line, fuse_and, fuse_or, fuse_delete_test,
        input fuse_mode_we, fuse_mode_oe,
        output registered_outputs, outputs_oe
    );

    modport host (
        output upper_inputs, lower_inputs, seq_step, preset_or_output_enable,
        output fuse_we, fuse_line, fuse_and, fuse_or, fuse_delete_test,
        output fuse_mode_we, fuse_mode_oe,
        input registered_outputs, outputs_oe
    );
endinterface
`default_nettype wire

//--- design/sps_device.sv
// Purpose: Mealy logic sequencer core with preset recovery and test array.
// Assumes: Pins sampled on clk; a step pulse stands for a rising clock.
// Notes: rst_b models power-up; fuses live in flip-flops.
`timescale 1ns/100ps
`default_nettype none
module sps_device
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    sps_link_if.dev link,
    output logic [SPS_ST_W-1:0] state_bits,
    output logic test_lines_live
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Each literal owns two fuses: even is true form, odd is complement.
    // An intact pair makes the term false, which is the blank state.
    function automatic logic sps_term(
        input logic [SPS_AND_W-1:0] mask,
        input logic [SPS_LIT_W-1:0] lits
    );
        logic t;
        t = 1'b1;
        for (int k = 0; k < SPS_LIT_W; k++) begin
            if (mask[2*k] && !lits[k]) begin
                t = 1'b0;
            end
            if (mask[2*k+1] && lits[k]) begin
                t = 1'b0;
            end
        end
        return t;
    endfunction

    // Set/reset flip-flop; both active holds, so a clash never toggles.
    function automatic logic sps_sr(
        input logic cur,
        input logic s,
        input logic r
    );
        logic n;
        n = cur;
        if (s && !r) begin
            n = 1'b1;
        end else if (r && !s) begin
            n = 1'b0;
        end
        return n;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    sps_dev_t q;
    sps_dev_t d;
    logic [SPS_LIT_W-1:0] lits;
    logic [SPS_OR_W-1:0] sums;
    logic [SPS_REG_W-1:0] regs;
    logic [SPS_REG_W-1:0] regs_nxt;
    logic preset_act;

    // ****************************************************************
    // Array evaluation
    // ****************************************************************

    // Literals 0-15 are the inputs, 16-21 the fed-back state bits.
    assign lits = {q.st, link.upper_inputs, link.lower_inputs};
    assign regs = {q.outr, q.st};

    // All fifty lines are summed in one clock, so the step rate never
    // depends on how many terms reach a sum line.
    always_comb begin
        sums = '0;
        for (int p = 0; p < SPS_LINES; p++) begin
            // Test lines drop out entirely once deleted.
            if (p < SPS_USER_LINES || q.test_live) begin
                if (sps_term(q.and_f[p], lits)) begin
                    sums = sums | q.or_f[p];
                end
            end
        end
    end

    always_comb begin
        regs_nxt = regs;
        for (int j = 0; j < SPS_REG_W; j++) begin
            regs_nxt[j] = sps_sr(regs[j], sums[2*j], sums[2*j+1]);
        end
    end

    // The pin presets only while the mode fuse is intact.
    assign preset_act = !q.mode_oe && link.preset_or_output_enable;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d = q;

        // Preset wins over any step in the same cycle.
        if (preset_act) begin
            d.st = SPS_ST_RST;
            d.outr = SPS_OUT_RST;
        end else if (link.seq_step) begin
            // No falling edge or idle step is needed after release.
            d.st = regs_nxt[SPS_ST_W-1:0];
            d.outr = regs_nxt[SPS_REG_W-1:SPS_ST_W];
        end

        // In enable mode the pin is an active-low output enable.
        if (q.mode_oe) begin
            d.oe = !link.preset_or_output_enable;
        end else begin
            d.oe = 1'b1;
        end

        // Fuse writes reach user lines only; test lines are fixed.
        if (link.fuse_we && link.fuse_line < 6'(SPS_USER_LINES)) begin
            d.and_f[link.fuse_line] = link.fuse_and;
            d.or_f[link.fuse_line] = link.fuse_or;
        end

        // Blowing is one-way: neither fuse can be restored.
        if (link.fuse_delete_test) begin
            d.test_live = 1'b0;
        end
        if (link.fuse_mode_we) begin
            d.mode_oe = q.mode_oe | link.fuse_mode_oe;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Power-up drives every state and output bit high.
    // Fuses also return to factory state here, which a real part
    // would not do; it keeps each simulation self-contained.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= SPS_DEV_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.registered_outputs = q.outr;
    assign link.outputs_oe = q.oe;
    assign state_bits = q.st;
    assign test_lines_live = q.test_live;

endmodule // sps_device
`default_nettype wire

//--- test/sps_link_monitor.sv
// Purpose: Checks the link between sequencer and system logic.
// Assumes: Fuse writes are seen on the link one edge before they act.
// Notes: Mode, test and user-line state is tracked from fuse strobes.
`timescale 1ns/100ps
`default_nettype none
module sps_link_monitor
    import sps_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] lower_inputs,
    input wire logic seq_step,
    input wire logic preset_or_output_enable,
    input wire logic [7:0] registered_outputs,
    input wire logic outputs_oe,
    input wire logic fuse_we,
    input wire logic [5:0] fuse_line,
    input wire logic fuse_delete_test,
    input wire logic fuse_mode_we,
    input wire logic fuse_mode_oe
);
    // ****************************************************************
    // Fuse tracking
    // ****************************************************************
    logic mode_q;
    logic test_q;
    logic user_q;
    logic pre_act;
    assign pre_act = !mode_q && preset_or_output_enable;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 1'b0;
            test_q <= 1'b1;
            user_q <= 1'b0;
        end else begin
            if (fuse_mode_we && fuse_mode_oe) mode_q <= 1'b1;
            if (fuse_delete_test) test_q <= 1'b0;
            if (fuse_we && fuse_line < 6'd48) user_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence preset_pulse_s;
        pre_act ##1 !pre_act;
    endsequence
    sequence test_step_s(v);
        test_q && !user_q && seq_step && !pre_act && lower_inputs[0] == v;
    endsequence
    reset_high_a: assert property ($rose(rst_b) |-> registered_outputs == 8'hff)
        else $error("outputs not high after reset");
    preset_force_a: assert property (pre_act |=> registered_outputs == 8'hff)
        else $error("preset did not force outputs high");
    preset_pulse_a: assert property (preset_pulse_s |-> registered_outputs == 8'hff)
        else $error("outputs not high after preset pulse");
    test_set_a: assert property (test_step_s(1'b1) |=> registered_outputs == 8'hff)
        else $error("test line did not set outputs");
    test_clear_a: assert property (test_step_s(1'b0) |=> registered_outputs == 8'h00)
        else $error("test line did not clear outputs");
    idle_hold_a: assert property (!seq_step && !pre_act |=> $stable(registered_outputs))
        else $error("outputs moved without a step");
    deleted_inert_a: assert property (!test_q && !user_q && seq_step |=> $stable(registered_outputs))
        else $error("deleted test lines still act");
    oe_follow_a: assert property (mode_q |=> outputs_oe == !$past(preset_or_output_enable))
        else $error("output enable does not follow pin");
    oe_fixed_a: assert property (!mode_q |-> outputs_oe)
        else $error("outputs disabled in preset mode");
endmodule // sps_link_monitor
`default_nettype wire

//--- test/sequencer_preset_test_array_test.sv
// Purpose: Drives system logic and sequencer together and checks results.
// Assumes: user_inputs[7:0] reach the lower inputs of the sequencer.
// Notes: User lines use lower literals only, so repeated steps settle.
`timescale 1ns/100ps
`default_nettype none
module sequencer_preset_test_array_test
    import sps_pkg::*;
;
    // ****************************************************************
    // Stimulus and model
    // ****************************************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic run_en = 1'b0, test_mode = 1'b0, preset_req = 1'b0, pin_idle = 1'b0;
    logic prog_we = 1'b0, prog_delete_test = 1'b0, prog_mode_we = 1'b0, prog_mode_oe = 1'b0;
    logic [15:0] user_inputs = 16'h0000;
    logic [5:0] prog_line = 6'h00;
    logic [SPS_AND_W-1:0] prog_and = '0;
    logic [SPS_OR_W-1:0] prog_or = '0;
    logic [7:0] outputs_seen;
    logic outputs_seen_oe, busy, test_lines_live;
    logic [5:0] state_bits;
    int n_fail = 0;
    int cmp_count = 0;
    integer seed = 32'h0624;
    logic [43:0] and_m [48];
    logic [27:0] or_m [48];
    logic [13:0] regs_m;
    logic [15:0] rv;
    sps_link_if link();
    sps_host u_sps_host(.clk(clk), .rst_b(rst_b), .link(link), .run_en(run_en),
        .test_mode(test_mode), .preset_req(preset_req), .pin_idle(pin_idle),
        .user_inputs(user_inputs), .prog_we(prog_we), .prog_line(prog_line),
        .prog_and(prog_and), .prog_or(prog_or), .prog_delete_test(prog_delete_test),
        .prog_mode_we(prog_mode_we), .prog_mode_oe(prog_mode_oe),
        .outputs_seen(outputs_seen), .outputs_seen_oe(outputs_seen_oe), .busy(busy));
    sps_device u_sps_device(.clk(clk), .rst_b(rst_b), .link(link),
        .state_bits(state_bits), .test_lines_live(test_lines_live));
    sps_link_monitor u_sps_link_monitor(.clk(clk), .rst_b(rst_b),
        .lower_inputs(link.lower_inputs), .seq_step(link.seq_step),
        .preset_or_output_enable(link.preset_or_output_enable),
        .registered_outputs(link.registered_outputs), .outputs_oe(link.outputs_oe),
        .fuse_we(link.fuse_we), .fuse_line(link.fuse_line),
        .fuse_delete_test(link.fuse_delete_test), .fuse_mode_we(link.fuse_mode_we),
        .fuse_mode_oe(link.fuse_mode_oe));
    always #25 clk = ~clk;
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic check_regs(input logic [13:0] r);
        chk("outputs_seen", {8'h00, outputs_seen}, {8'h00, r[13:6]});
        chk("state_bits", {10'h000, state_bits}, {10'h000, r[5:0]});
    endtask
    task automatic run_for(input logic [15:0] ui, input int n);
        user_inputs = ui;
        run_en = 1'b1;
        tick(n);
        run_en = 1'b0;
        tick(6);
    endtask
    task automatic prog(input logic [5:0] ln, input logic [43:0] a, input logic [27:0] o);
        prog_line = ln;
        prog_and = a;
        prog_or = o;
        prog_we = 1'b1;
        tick(1);
        prog_we = 1'b0;
        tick(3);
        if (ln < 6'd48) begin
            and_m[ln] = a;
            or_m[ln] = o;
        end
    endtask
    // Term is true when every connected literal matches; both fuses intact never match.
    function automatic logic [13:0] next_m(input logic [13:0] r, input logic [7:0] lo);
        logic [15:0] lx;
        logic [13:0] s;
        logic [13:0] c;
        s = '0;
        c = '0;
        for (int k = 0; k < 8; k++) begin
            lx[2*k] = lo[k];
            lx[2*k+1] = ~lo[k];
        end
        for (int l = 0; l < 48; l++) begin
            if (&(~and_m[l][15:0] | lx)) begin
                for (int j = 0; j < 14; j++) begin
                    s[j] = s[j] | or_m[l][2*j];
                    c[j] = c[j] | or_m[l][2*j+1];
                end
            end
        end
        return (r & ~(c & ~s)) | (s & ~c);
    endfunction
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #(SPS_CLK_NS * 4000);
        n_fail++;
        give_verdict();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        for (int l = 0; l < 48; l++) begin
            and_m[l] = SPS_AND_RST;
            or_m[l] = SPS_OR_RST;
        end
        tick(12);
        chk("outputs", {8'h00, link.registered_outputs}, 16'h00ff);
        chk("state", {10'h000, state_bits}, 16'h003f);
        chk("live", {15'h0000, test_lines_live}, 16'h0001);
        rst_b = 1'b1;
        chk("busy", {15'h0000, busy}, 16'h0001);
        tick(1);
        chk("busy", {15'h0000, busy}, 16'h0000);
        tick(2);
        test_mode = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rv = 16'($random(seed));
            run_for({rv[15:1], i[0]}, 12);
            regs_m = i[0] ? 14'h3fff : 14'h0000;
            check_regs(regs_m);
        end
        test_mode = 1'b0;
        $display("test array done");
        preset_req = 1'b1;
        tick(1);
        preset_req = 1'b0;
        chk("busy", {15'h0000, busy}, 16'h0001);
        tick(6);
        check_regs(14'h3fff);
        chk("busy", {15'h0000, busy}, 16'h0000);
        run_for(16'h0000, 12);
        check_regs(14'h0000);
        $display("preset recovery done");
        prog_delete_test = 1'b1;
        tick(1);
        prog_delete_test = 1'b0;
        tick(3);
        chk("live", {15'h0000, test_lines_live}, 16'h0000);
        run_for(16'h0001, 12);
        check_regs(14'h0000);
        prog(6'd48, 44'h0, 28'h555_5555);
        run_for(16'h0001, 12);
        check_regs(14'h0000);
        regs_m = 14'h0000;
        $display("test delete done");
        for (int i = 0; i < 6; i++) begin
            // The first line is a single true literal, so its sums really act.
            rv = 16'($random(seed));
            prog((i == 0) ? 6'd47 : 6'($unsigned($random(seed)) % 48),
                (i == 0) ? 44'h000_0000_0001 : {28'h0, rv}, 28'($random(seed)));
            rv = 16'($random(seed)) | 16'(i == 0);
            run_for(rv, 16);
            regs_m = next_m(regs_m, rv[7:0]);
            check_regs(regs_m);
        end
        $display("user lines done");
        prog_mode_oe = 1'b1;
        prog_mode_we = 1'b1;
        tick(1);
        prog_mode_we = 1'b0;
        pin_idle = 1'b1;
        tick(6);
        chk("oe", {15'h0000, outputs_seen_oe}, 16'h0000);
        pin_idle = 1'b0;
        preset_req = 1'b1;
        tick(1);
        preset_req = 1'b0;
        tick(6);
        chk("oe", {15'h0000, outputs_seen_oe}, 16'h0001);
        check_regs(regs_m);
        $display("output enable mode done");
        rst_b = 1'b0;
        tick(2);
        chk("outputs", {8'h00, link.registered_outputs}, 16'h00ff);
        chk("live", {15'h0000, test_lines_live}, 16'h0001);
        rst_b = 1'b1;
        chk("busy", {15'h0000, busy}, 16'h0001);
        tick(3);
        chk("busy", {15'h0000, busy}, 16'h0000);
        $display("second reset done");
        give_verdict();
    end
endmodule // sequencer_preset_test_array_test
`default_nettype wire
